// ==== hdl/boot_image_stream_parser.sv ====
// boot image stream parser: key, reserved words, entry point, blocks
// assumes a transport that offers one byte or word per in_valid strobe
//==============================================================================
`timescale 1ns/1ps
`include "stream_parser_map.svh"
module boot_image_stream_parser #(
    // reserved words between key and entry point
    parameter int RSVD_WORDS = int'(`RESERVED_COUNT)
) (
    // clock and reset
    input  wire logic                          ref_clk,
    input  wire logic                          rst_b,
    // boot mode width permissions
    input  wire logic                          allow_byte,
    input  wire logic                          allow_word,
    // inbound stream, low byte used in byte format
    input  wire logic                          in_valid,
    input  wire logic [15:0]                   in_data,
    // memory writes
    output stream_parser_pkg::mem_write_s      mem_wr,
    // load result
    output stream_parser_pkg::result_s         result
);
    typedef enum {
        S_KEY1, S_KEY2, S_RSVD, S_ENTRY_HI, S_ENTRY_LO,
        S_SIZE, S_ADDR_HI, S_ADDR_LO, S_DATA, S_DONE, S_ERROR
    } state_e;

    localparam logic [3:0] RSVD_LAST = 4'(RSVD_WORDS - 1);

    // states after the key in which stream words are parsed
    function automatic logic load_phase(state_e s);
        return s != S_KEY1 && s != S_KEY2 && s != S_DONE && s != S_ERROR;
    endfunction : load_phase

    //==========================================================================
    // parameter checks
    if (RSVD_WORDS < 1 || RSVD_WORDS > 15) begin : g_rsvd_check
        $error("reserved word count out of range");
    end

    //==========================================================================
    // reset release
    logic [1:0] rst_sync_q;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) rst_sync_q <= 2'h0;
        else        rst_sync_q <= {rst_sync_q[0], 1'h1};
    end
    wire rst_n_int = rst_sync_q[1];

    //==========================================================================
    // word assembly
    state_e                    state_q, state_d;
    stream_parser_pkg::fmt_e   fmt_q, fmt_d;
    logic                      half_q;
    logic [7:0]                low_q;
    logic [15:0]               first_q;
    logic [3:0]                rsvd_q;
    logic [15:0]               hi_q;
    logic [31:0]               entry_q;
    logic [15:0]               count_q;
    logic [31:0]               addr_q;
    logic [15:0]               word;
    logic                      word_ok;

    wire in_phase  = load_phase(state_q);
    wire byte_fmt  = fmt_q == stream_parser_pkg::FMT_BYTE;
    assign word    = byte_fmt ? {in_data[7:0], low_q} : in_data;
    assign word_ok = in_valid && in_phase && (!byte_fmt || half_q);
    wire [15:0] key8 = {in_data[7:0], first_q[7:0]};
    wire key16_hit = in_data == `KEY_WORD16;
    wire key8_hit  = key8 == `KEY_WORD8;
    wire data_take = word_ok && state_q == S_DATA;
    wire load_done = state_d == S_DONE;
    wire load_err  = state_d == S_ERROR;

    //==========================================================================
    // next state
    always_comb begin
        state_d = state_q;
        fmt_d   = fmt_q;
        case (state_q)
            S_KEY1: begin
                if (in_valid) begin
                    if (key16_hit && allow_word) begin
                        state_d = S_RSVD;
                        fmt_d   = stream_parser_pkg::FMT_WORD;
                    end else if (key16_hit) begin
                        state_d = S_ERROR;
                    end else begin
                        state_d = S_KEY2;
                    end
                end
            end
            S_KEY2: begin
                if (in_valid) begin
                    if (key8_hit && allow_byte) begin
                        state_d = S_RSVD;
                        fmt_d   = stream_parser_pkg::FMT_BYTE;
                    end else begin
                        state_d = S_ERROR;
                    end
                end
            end
            S_RSVD:     if (word_ok && rsvd_q == RSVD_LAST)
                            state_d = S_ENTRY_HI;
            S_ENTRY_HI: begin
                if (word_ok) begin
                    if (byte_fmt && word[15:8] != `ENTRY_TOP_BYTE)
                        state_d = S_ERROR;
                    else
                        state_d = S_ENTRY_LO;
                end
            end
            S_ENTRY_LO: if (word_ok) state_d = S_SIZE;
            S_SIZE:     if (word_ok)
                            state_d = (word == `SIZE_END) ? S_DONE : S_ADDR_HI;
            S_ADDR_HI:  if (word_ok) state_d = S_ADDR_LO;
            S_ADDR_LO:  if (word_ok) state_d = S_DATA;
            S_DATA:     if (word_ok && count_q == 16'h0001)
                            state_d = S_SIZE;
            S_DONE:     state_d = S_DONE;
            S_ERROR:    state_d = S_ERROR;
            default:    state_d = S_ERROR;
        endcase
    end

    //==========================================================================
    // state and datapath registers
    always_ff @(posedge ref_clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            state_q <= S_KEY1;
            fmt_q   <= stream_parser_pkg::FMT_NONE;
            half_q  <= 1'h0;
            low_q   <= 8'h00;
            first_q <= 16'h0000;
        end else begin
            state_q <= state_d;
            fmt_q   <= fmt_d;
            if (state_q == S_KEY1 && in_valid) first_q <= in_data;
            if (in_valid && in_phase && byte_fmt) begin
                half_q <= ~half_q;
                if (!half_q) low_q <= in_data[7:0];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            rsvd_q  <= 4'h0;
            hi_q    <= 16'h0000;
            entry_q <= 32'h0000_0000;
            count_q <= 16'h0000;
            addr_q  <= 32'h0000_0000;
        end else if (word_ok) begin
            case (state_q)
                S_RSVD:     rsvd_q  <= rsvd_q + 4'h1;
                S_ENTRY_HI: hi_q    <= word;
                S_ENTRY_LO: entry_q <= {hi_q, word};
                S_SIZE:     count_q <= word;
                S_ADDR_HI:  hi_q    <= word;
                S_ADDR_LO:  addr_q  <= {hi_q, word};
                S_DATA: begin
                    addr_q  <= addr_q + 32'h0000_0001;
                    count_q <= count_q - 16'h0001;
                end
                default:    rsvd_q  <= rsvd_q;
            endcase
        end
    end

    //==========================================================================
    // outputs
    always_ff @(posedge ref_clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            mem_wr <= '0;
        end else begin
            mem_wr.valid <= data_take;
            mem_wr.addr  <= addr_q;
            mem_wr.data  <= word;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            result <= '0;
        end else begin
            result.done          <= load_done;
            result.error         <= load_err;
            result.reset_req     <= load_err;
            result.entry_address <= load_done ? entry_q : 32'h0000_0000;
        end
    end

    //==========================================================================
    // assertions
    a_done_err_excl: assert property (
        @(posedge ref_clk) disable iff (!rst_n_int)
        !(result.done && result.error))
        else $error("done and error together");
    a_done_entry: assert property (
        @(posedge ref_clk) disable iff (!rst_n_int)
        result.done |-> result.entry_address == entry_q)
        else $error("entry point not presented");
    a_entry_hold: assert property (
        @(posedge ref_clk) disable iff (!rst_n_int)
        result.done |=> $stable(result.entry_address))
        else $error("entry point moved after done");
    a_word_key: assert property (
        @(posedge ref_clk) disable iff (!rst_n_int)
        state_q == S_KEY1 && in_valid && in_data == `KEY_WORD16 && allow_word
        |=> state_q == S_RSVD && fmt_q == stream_parser_pkg::FMT_WORD)
        else $error("word key missed");
    a_byte_key: assert property (
        @(posedge ref_clk) disable iff (!rst_n_int)
        state_q == S_KEY2 && in_valid && key8_hit && allow_byte
        |=> fmt_q == stream_parser_pkg::FMT_BYTE)
        else $error("byte key missed");
    a_bad_key: assert property (
        @(posedge ref_clk) disable iff (!rst_n_int)
        state_q == S_KEY2 && in_valid && !key8_hit
        |=> result.error && result.reset_req)
        else $error("bad key not aborted");
    a_reset_req: assert property (
        @(posedge ref_clk) disable iff (!rst_n_int)
        result.reset_req == result.error)
        else $error("reset request differs from error");
    a_key_no_write: assert property (
        @(posedge ref_clk) disable iff (!rst_n_int)
        !load_phase(state_q) |=> !mem_wr.valid)
        else $error("write outside load phase");
    a_err_sticky: assert property (
        @(posedge ref_clk) disable iff (!rst_n_int)
        result.error |=> result.error)
        else $error("error dropped");
    a_rsvd_count: assert property (
        @(posedge ref_clk) disable iff (!rst_n_int)
        state_q == S_RSVD && word_ok && rsvd_q == RSVD_LAST |=> state_q == S_ENTRY_HI)
        else $error("reserved count wrong");
    a_entry_top: assert property (
        @(posedge ref_clk) disable iff (!rst_n_int)
        state_q == S_ENTRY_HI && word_ok && byte_fmt && word[15:8] != `ENTRY_TOP_BYTE
        |=> result.error)
        else $error("entry top byte not refused");
    a_size_load: assert property (
        @(posedge ref_clk) disable iff (!rst_n_int)
        state_q == S_SIZE && word_ok && word != `SIZE_END |=> count_q == $past(word))
        else $error("block size not taken");
    a_msw_first: assert property (
        @(posedge ref_clk) disable iff (!rst_n_int)
        state_q == S_ADDR_LO && word_ok |=> addr_q == {$past(hi_q), $past(word)})
        else $error("address word order wrong");
    a_block_next: assert property (
        @(posedge ref_clk) disable iff (!rst_n_int)
        state_q == S_DATA && word_ok && count_q == 16'h0001 |=> state_q == S_SIZE)
        else $error("next block header missed");
    a_addr_step: assert property (
        @(posedge ref_clk) disable iff (!rst_n_int)
        data_take |=> addr_q == $past(addr_q) + 32'h0000_0001)
        else $error("address not stepped");
    a_write_addr: assert property (
        @(posedge ref_clk) disable iff (!rst_n_int)
        data_take |=> mem_wr.valid && mem_wr.addr == $past(addr_q))
        else $error("write missing");
    a_zero_end: assert property (
        @(posedge ref_clk) disable iff (!rst_n_int)
        word_ok && state_q == S_SIZE && word == `SIZE_END |=> result.done)
        else $error("terminator missed");
    a_hold_idle: assert property (
        @(posedge ref_clk) disable iff (!rst_n_int)
        !in_valid |=> state_q == $past(state_q))
        else $error("state moved without strobe");
    a_no_rsvd_write: assert property (
        @(posedge ref_clk) disable iff (!rst_n_int)
        state_q == S_RSVD |=> !mem_wr.valid)
        else $error("reserved word wrote memory");
    a_byte_pair: assert property (
        @(posedge ref_clk) disable iff (!rst_n_int)
        byte_fmt && state_q == S_DATA && in_valid && !half_q |=> !mem_wr.valid)
        else $error("write on low byte");
    a_low_latch: assert property (
        @(posedge ref_clk) disable iff (!rst_n_int)
        byte_fmt && in_phase && in_valid && !half_q |=> low_q == $past(in_data[7:0]))
        else $error("low byte not kept");

    //==========================================================================
    // covers
    c_word_done: cover property (@(posedge ref_clk) disable iff (!rst_n_int)
        result.done && fmt_q == stream_parser_pkg::FMT_WORD);
    c_byte_done: cover property (@(posedge ref_clk) disable iff (!rst_n_int)
        result.done && fmt_q == stream_parser_pkg::FMT_BYTE);
    c_abort: cover property (@(posedge ref_clk) disable iff (!rst_n_int)
        result.error);
    c_byte_write: cover property (@(posedge ref_clk) disable iff (!rst_n_int)
        data_take && byte_fmt);
    c_gap_hold: cover property (@(posedge ref_clk) disable iff (!rst_n_int)
        state_q == S_DATA && !in_valid);
endmodule : boot_image_stream_parser

// ==== shared/stream_parser_map.svh ====
// constants for the boot image stream parser
// assumes inclusion by bare name from the design
`ifndef STREAM_PARSER_MAP_SVH
`define STREAM_PARSER_MAP_SVH
`define KEY_WORD16        16'h10AA
`define KEY_WORD8         16'h08AA
`define KEY_BYTE_LOW      8'hAA
`define RESERVED_COUNT    4'h8
`define ENTRY_TOP_BYTE    8'h00
`define SIZE_END          16'h0000
`endif

// ==== shared/stream_parser_pkg.sv ====
// types for the boot image stream parser
// does not include stream_parser_map.svh and needs nothing from it
package stream_parser_pkg;
    typedef enum logic [1:0] {
        FMT_NONE,
        FMT_BYTE,
        FMT_WORD
    } fmt_e;
    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
        logic [15:0] data;
    } mem_write_s;
    typedef struct packed {
        logic        done;
        logic        error;
        logic        reset_req;
        logic [31:0] entry_address;
    } result_s;
endpackage : stream_parser_pkg

// ==== dv/boot_host.sv ====
// host model that feeds a boot image into the stream parser
// assumes the bench calls send_word just after a rising edge of ref_clk
//==============================================================================
// Host
`timescale 1ns/1ps
module boot_host (
    // clock
    input  wire logic        ref_clk,
    // outbound stream
    output logic             in_valid,
    output logic [15:0]      in_data
);
    initial begin
        in_valid = 1'b0;
        in_data  = 16'h0000;
    end
    // one strobe per unit, held until the sampling edge, inverse data when idle
    task automatic send(input logic [15:0] v, input int gap);
        in_valid = 1'b1;
        in_data  = v;
        @(posedge ref_clk);
        #1;
        if (gap > 0) begin
            in_valid = 1'b0;
            in_data  = ~v;
            repeat (gap) begin
                @(posedge ref_clk);
                #1;
            end
        end
    endtask : send
    // byte format sends low byte then high byte; upper lane carries junk
    task automatic send_word(input bit byte_fmt, input logic [15:0] w, input int gap);
        if (byte_fmt) begin
            send({~w[7:0], w[7:0]}, 0);
            send({~w[15:8], w[15:8]}, gap);
        end else begin
            send(w, gap);
        end
    endtask : send_word
endmodule : boot_host

// ==== dv/testbench.sv ====
// self-checking bench for the boot image stream parser
// assumes the design files and the package are compiled first
//==============================================================================
// Bench
`timescale 1ns/1ps
module testbench;
    logic                          ref_clk;
    logic                          rst_b;
    logic                          allow_byte;
    logic                          allow_word;
    logic                          in_valid;
    logic [15:0]                   in_data;
    stream_parser_pkg::mem_write_s mem_wr;
    stream_parser_pkg::result_s    result;
    int                            failures = 0;
    int                            num_checks = 0;
    int                            cycles = 0;
    logic [31:0]                   lfsr = 32'hFF8CE448;
    logic [31:0]                   exp_ent;
    logic [47:0]                   exp_q[$];
    logic [15:0]                   img[$];

    boot_host u_boot_host (.ref_clk(ref_clk), .in_valid(in_valid), .in_data(in_data));
    boot_image_stream_parser u_boot_image_stream_parser (
        .ref_clk(ref_clk), .rst_b(rst_b), .allow_byte(allow_byte), .allow_word(allow_word),
        .in_valid(in_valid), .in_data(in_data), .mem_wr(mem_wr), .result(result));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    function automatic logic [31:0] next_rand();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction : next_rand
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic end_sim();
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_sim
    // image: key, 8 reserved, entry, two blocks of 1..4 words, terminator
    task automatic build(input bit byte_fmt, input bit bad_top);
        logic [31:0] a;
        logic [15:0] n;
        logic [15:0] d;
        img = {};
        exp_q = {};
        exp_ent = next_rand() & 32'h00FFFFFF;
        if (bad_top) exp_ent[31:24] = 8'h01;
        img.push_back(byte_fmt ? 16'h08AA : 16'h10AA);
        repeat (8) img.push_back(16'(next_rand()));
        img.push_back(exp_ent[31:16]);
        img.push_back(exp_ent[15:0]);
        repeat (2) begin
            n = 16'(next_rand() % 4 + 1);
            a = next_rand();
            img.push_back(n);
            img.push_back(a[31:16]);
            img.push_back(a[15:0]);
            repeat (n) begin
                d = 16'(next_rand());
                img.push_back(d);
                exp_q.push_back({a, d});
                a++;
            end
        end
        img.push_back(16'h0000);
    endtask : build
    // mode 0: clean load, 1: refused width, 2: bad key, 3: bad entry top byte
    task automatic run(input bit byte_fmt, input bit aw, input bit ab, input int mode);
        build(byte_fmt, mode == 3);
        if (mode == 2) img[0] = 16'h1234;
        if (mode != 0) exp_q = {};
        @(posedge ref_clk);
        #1;
        rst_b = 1'b0;
        allow_word = aw;
        allow_byte = ab;
        repeat (2) @(posedge ref_clk);
        #1;
        rst_b = 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        check(48'(result), 48'h0);
        check(48'(mem_wr.valid), 48'h0);
        foreach (img[i])
            u_boot_host.send_word(byte_fmt, img[i], (i == img.size() - 1) ? 1 : next_rand() % 3);
        repeat (2) @(posedge ref_clk);
        #1;
        if (mode == 0) check(48'(result), 48'({3'b100, exp_ent}));
        else check(48'(result), 48'({3'b011, 32'h0}));
        check(48'(exp_q.size()), 48'h0);
        repeat (3) u_boot_host.send_word(byte_fmt, 16'h0003, 1);
        repeat (2) @(posedge ref_clk);
        #1;
        if (mode == 0) check(48'(result), 48'({3'b100, exp_ent}));
    endtask : run

    always @(posedge ref_clk) begin
        if (mem_wr.valid === 1'b1) begin
            if (exp_q.size() == 0) check(48'h1, 48'h0);
            else check({mem_wr.addr, mem_wr.data}, exp_q.pop_front());
        end
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            end_sim();
        end
    end
    initial begin
        rst_b = 1'b0;
        allow_byte = 1'b1;
        allow_word = 1'b1;
        run(1'b0, 1'b1, 1'b1, 0);
        run(1'b1, 1'b1, 1'b1, 0);
        repeat (4) run(next_rand() % 2 == 1, 1'b1, 1'b1, 0);
        run(1'b0, 1'b0, 1'b1, 1);
        run(1'b1, 1'b1, 1'b0, 1);
        run(1'b0, 1'b1, 1'b1, 2);
        run(1'b1, 1'b1, 1'b1, 3);
        end_sim();
    end
endmodule : testbench
